// ===== flash_prot_regs.vh
`ifndef FLASH_PROT_REGS_VH
`define FLASH_PROT_REGS_VH

// ****************************************
// Register indices (Avalon word address)
// ****************************************
`define OFS_FLASH_CONFIG 4'h4
`define OFS_IRQ_ENABLE 4'h5
`define OFS_FLASH_STATUS 4'h6
`define OFS_ERROR_STATUS 4'h7
`define OFS_PROTECTION 4'h8

// ****************************************
// Field positions
// ****************************************
`define BIT_SINGLE_FAULT 0
`define BIT_DOUBLE_FAULT 1
`define BIT_IGNORE_SINGLE 4
`define BIT_PROT_VIOL 4
`define BIT_PROT_OPEN 7
`define BIT_RSV_NV 6
`define BIT_HIGH_DIS 5
`define BIT_LOW_DIS 2
`define HIGH_SIZE_MSB 4
`define HIGH_SIZE_LSB 3
`define LOW_SIZE_MSB 1
`define LOW_SIZE_LSB 0

// ****************************************
// Reset values and addresses
// ****************************************
`define PROT_RESET 8'h7F
`define PROT_FAULT_VALUE 8'h7F
`define CONFIG_RESET 8'h00
`define PROT_BYTE_ADDR 18'h3FF0C
`define PFLASH_LOW_ADDR 18'h38000
`define PFLASH_TOP_ADDR 18'h3FFFF
`define SECTOR_SHIFT 10
`define ECC_FLAG_DELAY 1

`endif

// ===== fault_flags.v
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Sticky fault flags, write one to clear
// ****************************************
module fault_flags (
	input wire core_clk,
	input wire resetn,
	input wire [1:0] set_flag,
	input wire [1:0] clr_flag,
	output reg [1:0] flag
);

	// A set arriving with a clear wins, so no event is lost
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flag <= 2'h0;
		end else begin
			flag <= (flag & ~clr_flag) | set_flag;
		end
	end

endmodule
`default_nettype wire

// ===== prot_range_map.v
`timescale 1ns/10ps
`default_nettype none
`include "flash_prot_regs.vh"

// ****************************************
// Protection byte to 1 KB sector mask
// ****************************************
module prot_range_map (
	input wire [7:0] prot,
	output reg [31:0] mask
);

	reg [31:0] high_sect;
	reg [31:0] low_sect;
	reg [31:0] active;
	reg [5:0] high_cnt;
	reg [4:0] low_cnt;
	integer i;

	always @* begin
		high_cnt = 6'h02 << prot[`HIGH_SIZE_MSB:`HIGH_SIZE_LSB];
		low_cnt = 5'h01 << prot[`LOW_SIZE_MSB:`LOW_SIZE_LSB];
		for (i = 0; i < 32; i = i + 1) begin
			high_sect[i] = (i >= 32 - high_cnt);
			low_sect[i] = (i < low_cnt);
		end
		active = ({32{~prot[`BIT_HIGH_DIS]}} & high_sect) |
			({32{~prot[`BIT_LOW_DIS]}} & low_sect);
		// Open bit set: ranges protect; clear: ranges unprotect
		if (prot[`BIT_PROT_OPEN]) begin
			mask = active;
		end else begin
			mask = ~active;
		end
	end

endmodule
`default_nettype wire

// ===== flash_ecc_prot.v
`timescale 1ns/10ps
`default_nettype none
`include "flash_prot_regs.vh"

// Operation
// - double-bit error or busy-block read sets double flag
// - double flag clears only on written one
// - single fault sets single flag unless ignored
// - single flag clears only on written one
// - ECC event sets single or double, not both
// - access collision sets both fault flags
// - fault flags appear two cycles after read
// - protection writes may only grow protection
// - reset loads protection byte from flash
// - double fault on load protects everything
// - protected program/erase refused, violation flagged
// - block erase refused if any sector protected
// - open bit and disables decode protection function
// - high range ends top, low starts bottom
// - high size gives 2, 4, 8, 16 KB
// - low size gives 1, 2, 4, 8 KB
// - high size writable only while high disabled
// - low size writable only while low disabled
// - ignore bit suppresses single fault and interrupt
// - interrupt when enabled fault flag set
// - violation flag W1C, blocks command launch
module flash_ecc_prot (
	input wire core_clk,
	input wire resetn,
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	input wire array_rd_valid,
	input wire array_rd_single,
	input wire array_rd_double,
	input wire array_rd_collision,
	output reg boot_rd_req,
	output reg [17:0] boot_rd_addr,
	input wire boot_rd_valid,
	input wire [7:0] boot_rd_data,
	input wire boot_rd_double,
	input wire cmd_req,
	input wire cmd_block_erase,
	input wire [17:0] cmd_addr,
	output reg cmd_accept,
	output reg cmd_refuse,
	output reg prot_loaded,
	output reg fault_irq
);

	// ****************************************
	// Local definitions
	// ****************************************
	localparam [1:0] BOOT_IDLE = 2'b00;
	localparam [1:0] BOOT_WAIT = 2'b01;
	localparam [1:0] BOOT_DONE = 2'b10;

	reg [1:0] boot_state;
	reg [1:0] next_boot_state;
	reg [7:0] program_flash_protection;
	reg [7:0] flash_config_reg;
	reg [1:0] irq_enable;
	reg protection_violation_flag;
	reg [1:0] fault_event;
	wire [1:0] fault_flag;
	wire double_fault_flag;
	wire single_fault_flag;
	wire ignore_single_fault;
	wire protection_operation_bit;
	wire high_range_disable;
	wire low_range_disable;
	wire double_fault_irq_enable;
	wire single_fault_irq_enable;
	wire [31:0] cur_mask;
	wire [31:0] cand_mask;
	reg [7:0] prot_candidate;
	reg [7:0] wbyte;
	reg wr_ok;
	reg rd_ok;
	reg wr_error_status;
	reg wr_prot;
	reg [1:0] fault_clear;
	reg viol_clear;
	reg viol_set;
	reg addr_protected;
	reg refuse_now;
	reg [7:0] read_mux;

	// ****************************************
	// Helpers
	// ****************************************
	function in_pflash_window;
		input [17:0] addr;
		begin
			in_pflash_window = (addr >= `PFLASH_LOW_ADDR) &&
				(addr <= `PFLASH_TOP_ADDR);
		end
	endfunction

	function [4:0] sector_of;
		input [17:0] addr;
		reg [17:0] offs;
		begin
			offs = addr - `PFLASH_LOW_ADDR;
			sector_of = offs[14:`SECTOR_SHIFT];
		end
	endfunction

	assign protection_operation_bit = program_flash_protection[`BIT_PROT_OPEN];
	assign high_range_disable = program_flash_protection[`BIT_HIGH_DIS];
	assign low_range_disable = program_flash_protection[`BIT_LOW_DIS];
	assign ignore_single_fault = flash_config_reg[`BIT_IGNORE_SINGLE];
	assign double_fault_irq_enable = irq_enable[`BIT_DOUBLE_FAULT];
	assign single_fault_irq_enable = irq_enable[`BIT_SINGLE_FAULT];
	assign double_fault_flag = fault_flag[`BIT_DOUBLE_FAULT];
	assign single_fault_flag = fault_flag[`BIT_SINGLE_FAULT];

	// ****************************************
	// Protection range decode
	// ****************************************
	prot_range_map cur_map (
		.prot(program_flash_protection),
		.mask(cur_mask)
	);

	prot_range_map cand_map (
		.prot(prot_candidate),
		.mask(cand_mask)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	// Answer is given one cycle after the request is seen
	always @* begin
		wbyte = writedata[7:0];
		wr_ok = write && !waitrequest && byteenable[0];
		rd_ok = read && waitrequest;
		wr_error_status = wr_ok && (address == `OFS_ERROR_STATUS);
		wr_prot = wr_ok && (address == `OFS_PROTECTION);
		fault_clear = 2'h0;
		if (wr_error_status) begin
			fault_clear = wbyte[1:0];
		end
		viol_clear = wr_ok && (address == `OFS_FLASH_STATUS) &&
			wbyte[`BIT_PROT_VIOL];
	end

	always @* begin
		case (address)
			`OFS_FLASH_CONFIG: read_mux = flash_config_reg;
			`OFS_IRQ_ENABLE: read_mux = {6'h00, irq_enable};
			`OFS_FLASH_STATUS:
				read_mux = {3'h0, protection_violation_flag, 4'h0};
			`OFS_ERROR_STATUS: read_mux = {6'h00, fault_flag};
			`OFS_PROTECTION: begin
				read_mux = program_flash_protection;
				read_mux[`BIT_PROT_OPEN] = protection_operation_bit;
			end
			default: read_mux = 8'h00;
		endcase
	end

	// Fixed single wait state; the master must hold its request until then
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else begin
			if (!waitrequest) begin
				waitrequest <= 1'b1;
			end else if (read || write) begin
				waitrequest <= 1'b0;
			end
			if (rd_ok) begin
				readdata <= {24'h000000, read_mux};
			end
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flash_config_reg <= `CONFIG_RESET;
			irq_enable <= 2'h0;
		end else if (wr_ok) begin
			if (address == `OFS_FLASH_CONFIG) begin
				flash_config_reg <= {3'h0, wbyte[`BIT_IGNORE_SINGLE], 4'h0};
			end
			if (address == `OFS_IRQ_ENABLE) begin
				irq_enable <= wbyte[1:0];
			end
		end
	end

	// ****************************************
	// ECC fault capture
	// ****************************************
	// Events are staged one cycle, matching the documented delay
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fault_event <= 2'h0;
		end else if (array_rd_valid) begin
			fault_event[`BIT_DOUBLE_FAULT] <= array_rd_double ||
				array_rd_collision;
			fault_event[`BIT_SINGLE_FAULT] <= array_rd_collision ||
				(array_rd_single && !array_rd_double &&
				!ignore_single_fault);
		end else begin
			fault_event <= 2'h0;
		end
	end

	fault_flags err_flags (
		.core_clk(core_clk),
		.resetn(resetn),
		.set_flag(fault_event),
		.clr_flag(fault_clear),
		.flag(fault_flag)
	);

	// Ignore bit also masks a single flag still standing
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fault_irq <= 1'b0;
		end else begin
			fault_irq <= (double_fault_flag && double_fault_irq_enable) ||
				(single_fault_flag && single_fault_irq_enable &&
				!ignore_single_fault);
		end
	end

	// ****************************************
	// Reset sequence: fetch protection byte
	// ****************************************
	always @* begin
		next_boot_state = boot_state;
		case (boot_state)
			BOOT_IDLE: next_boot_state = BOOT_WAIT;
			BOOT_WAIT: begin
				if (boot_rd_valid) begin
					next_boot_state = BOOT_DONE;
				end
			end
			BOOT_DONE: next_boot_state = BOOT_DONE;
			default: next_boot_state = BOOT_IDLE;
		endcase
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			boot_state <= BOOT_IDLE;
			boot_rd_req <= 1'b0;
			boot_rd_addr <= 18'h00000;
			prot_loaded <= 1'b0;
		end else begin
			boot_state <= next_boot_state;
			boot_rd_req <= (boot_state == BOOT_IDLE);
			boot_rd_addr <= `PROT_BYTE_ADDR;
			prot_loaded <= (next_boot_state == BOOT_DONE);
		end
	end

	// ****************************************
	// Protection register update
	// ****************************************
	// Size fields follow the written value only while disabled
	always @* begin
		prot_candidate = program_flash_protection;
		prot_candidate[`BIT_PROT_OPEN] = wbyte[`BIT_PROT_OPEN];
		prot_candidate[`BIT_HIGH_DIS] = wbyte[`BIT_HIGH_DIS];
		prot_candidate[`BIT_LOW_DIS] = wbyte[`BIT_LOW_DIS];
		if (high_range_disable) begin
			prot_candidate[`HIGH_SIZE_MSB:`HIGH_SIZE_LSB] =
				wbyte[`HIGH_SIZE_MSB:`HIGH_SIZE_LSB];
		end
		if (low_range_disable) begin
			prot_candidate[`LOW_SIZE_MSB:`LOW_SIZE_LSB] =
				wbyte[`LOW_SIZE_MSB:`LOW_SIZE_LSB];
		end
	end

	// Reserved bit keeps its loaded value; software cannot touch it
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			program_flash_protection <= `PROT_RESET;
		end else if (boot_state == BOOT_WAIT && boot_rd_valid) begin
			if (boot_rd_double) begin
				program_flash_protection <= `PROT_FAULT_VALUE;
			end else begin
				program_flash_protection <= boot_rd_data;
			end
		end else if (wr_prot && boot_state == BOOT_DONE) begin
			if ((cur_mask & ~cand_mask) == 32'h00000000) begin
				program_flash_protection <= prot_candidate;
			end
		end
	end

	// ****************************************
	// Command admission
	// ****************************************
	// Until the byte is loaded every command is refused
	always @* begin
		addr_protected = in_pflash_window(cmd_addr) &&
			cur_mask[sector_of(cmd_addr)];
		if (cmd_block_erase) begin
			addr_protected = (cur_mask != 32'h00000000);
		end
		viol_set = cmd_req && !protection_violation_flag &&
			prot_loaded && addr_protected;
		refuse_now = protection_violation_flag ||
			!prot_loaded || addr_protected;
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cmd_accept <= 1'b0;
			cmd_refuse <= 1'b0;
			protection_violation_flag <= 1'b0;
		end else begin
			// Answer and violation flag share one edge, so both show together
			cmd_accept <= cmd_req && !refuse_now;
			cmd_refuse <= cmd_req && refuse_now;
			if (viol_set) begin
				protection_violation_flag <= 1'b1;
			end else if (viol_clear) begin
				protection_violation_flag <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ===== fep_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Port checker for the flash protection block
// ****************************************
module fep_asserts (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] address,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic waitrequest,
	input wire logic array_rd_valid,
	input wire logic array_rd_double,
	input wire logic array_rd_collision,
	input wire logic boot_rd_req,
	input wire logic [17:0] boot_rd_addr,
	input wire logic boot_rd_valid,
	input wire logic boot_rd_double,
	input wire logic cmd_req,
	input wire logic cmd_accept,
	input wire logic cmd_refuse,
	input wire logic prot_loaded,
	input wire logic fault_irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	logic full;
	logic [1:0] en;
	// Shadow of the enables and of a faulty boot load
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			full <= 1'b0;
			en <= 2'h0;
		end else begin
			if (boot_rd_valid && !prot_loaded)
				full <= boot_rd_double;
			if (write && !waitrequest && address == 4'h5 && byteenable[0])
				en <= writedata[1:0];
		end
	end
	a_boot_addr: assert property (
		boot_rd_req |-> boot_rd_addr == 18'h3FF0C) else $error("boot address");
	a_boot_once: assert property (
		boot_rd_req |=> !boot_rd_req [*8]) else $error("boot fetch repeated");
	a_load_flag: assert property (
		boot_rd_valid && !prot_loaded |=> prot_loaded) else $error("no load");
	a_load_stays: assert property (
		prot_loaded |=> prot_loaded) else $error("loaded flag dropped");
	a_early_refuse: assert property (
		cmd_req && !prot_loaded |=> cmd_refuse) else $error("early command");
	a_one_answer: assert property (
		cmd_req |=> $onehot({cmd_accept, cmd_refuse})) else $error("answer");
	a_no_stray: assert property (
		!cmd_req |=> !cmd_accept && !cmd_refuse) else $error("stray answer");
	a_full_refuse: assert property (
		full && cmd_req |=> cmd_refuse) else $error("full protect broken");
	a_irq_delay: assert property (
		array_rd_valid && (array_rd_double || array_rd_collision) && en[1]
		|-> ##3 fault_irq) else $error("double fault irq late");
endmodule
bind flash_ecc_prot fep_asserts u_chk (.*);
`default_nettype wire

// ===== flash_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Flash array side: answers the boot fetch
// ****************************************
module flash_partner (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic boot_rd_req,
	input wire logic [7:0] boot_byte,
	input wire logic boot_dbl,
	input wire logic [3:0] lat,
	output logic boot_rd_valid,
	output wire logic [7:0] boot_rd_data,
	output wire logic boot_rd_double
);
	logic busy;
	logic [3:0] cnt;
	logic [7:0] pat;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			pat <= 8'hA5;
			boot_rd_valid <= 1'b0;
		end else begin
			pat <= ~pat;
			boot_rd_valid <= 1'b0;
			if (boot_rd_req) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
				busy <= cnt != 4'h0;
				boot_rd_valid <= cnt == 4'h0;
			end
		end
	end
	// Reserved bit stays erased; idle lines wander so stale data is unseen
	assign boot_rd_data = boot_rd_valid ?
		{boot_byte[7], 1'b1, boot_byte[5:0]} : pat;
	assign boot_rd_double = boot_rd_valid ? boot_dbl : pat[0];
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic read = 1'b0, write = 1'b0, array_rd_valid = 1'b0, cmd_req = 1'b0;
	logic cmd_block_erase = 1'b0, boot_dbl = 1'b0, loaded, viol, ign;
	logic [3:0] address = 4'h0, byteenable = 4'hF, lat = 4'h0;
	logic [31:0] writedata = 32'h0, readdata;
	logic [2:0] aq = 3'h0;
	logic [17:0] cmd_addr = 18'h0;
	logic [7:0] boot_byte = 8'h00, cur, n, boot_rd_data;
	logic [15:0] rnd = 16'hCD1B, e;
	logic [1:0] f, en;
	logic waitrequest, boot_rd_req, boot_rd_valid, boot_rd_double;
	logic cmd_accept, cmd_refuse, fault_irq;
	logic [15:0] rq[$];
	logic [1:0] cq[$];
	int err_count = 0, num_checks = 0, t;
	flash_ecc_prot dut (.core_clk(core_clk), .resetn(resetn),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .array_rd_valid(array_rd_valid),
		.array_rd_single(aq[0]), .array_rd_double(aq[1]),
		.array_rd_collision(aq[2]), .boot_rd_req(boot_rd_req),
		.boot_rd_addr(), .boot_rd_valid(boot_rd_valid),
		.boot_rd_data(boot_rd_data), .boot_rd_double(boot_rd_double),
		.cmd_req(cmd_req), .cmd_block_erase(cmd_block_erase),
		.cmd_addr(cmd_addr), .cmd_accept(cmd_accept),
		.cmd_refuse(cmd_refuse), .prot_loaded(), .fault_irq(fault_irq));
	flash_partner u_part (.core_clk(core_clk), .resetn(resetn),
		.boot_rd_req(boot_rd_req), .boot_byte(boot_byte), .boot_dbl(boot_dbl),
		.lat(lat), .boot_rd_valid(boot_rd_valid),
		.boot_rd_data(boot_rd_data), .boot_rd_double(boot_rd_double));
	always #2.5 core_clk = ~core_clk;
	// ****************************************
	// Reference model and checks
	// ****************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic hit(input logic [7:0] p, input logic [17:0] a);
		logic h;
		logic l;
		h = !p[5] && {1'b0, a} >= 19'h40000 - (19'h800 << p[4:3]);
		l = !p[2] && a < 18'h38000 + (18'h400 << p[1:0]);
		return a >= 18'h38000 && (p[7] ? h || l : !(h || l));
	endfunction
	// Any sector protected under o but free under n
	function automatic logic shrinks(input logic [7:0] o, input logic [7:0] n);
		logic s;
		logic [17:0] a;
		s = 1'b0;
		for (int k = 0; k < 32; k++) begin
			a = 18'h38000 + 18'(k << 10);
			s |= hit(o, a) && !hit(n, a);
		end
		return s;
	endfunction
	task chk(input logic ok, input string m);
		num_checks++;
		if (!ok) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task final_report();
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (read && !waitrequest) begin
			e = rq.pop_front();
			chk((readdata[7:0] & e[15:8]) === e[7:0], "register read");
		end
		if (cmd_accept || cmd_refuse)
			chk({cmd_accept, cmd_refuse} === cq.pop_front(), "command");
	end
	// ****************************************
	// Drivers
	// ****************************************
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be);
		@(posedge core_clk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
		rq.push_back({m, v});
		bus(1'b0, a, 8'h00, 4'hF);
	endtask
	task cmd(input logic b, input logic [17:0] a);
		logic r;
		r = !loaded || viol || hit(cur, a) || (b && shrinks(cur, 8'hA4));
		viol |= r && loaded;
		cq.push_back({!r, r});
		@(posedge core_clk);
		cmd_req <= 1'b1;
		cmd_block_erase <= b;
		cmd_addr <= a;
		@(posedge core_clk);
		cmd_req <= 1'b0;
	endtask
	task ev(input logic [2:0] q);
		@(posedge core_clk);
		array_rd_valid <= 1'b1;
		aq <= q;
		@(posedge core_clk);
		array_rd_valid <= 1'b0;
	endtask
	task do_reset(input logic [7:0] b, input logic d);
		boot_byte = b;
		boot_dbl = d;
		loaded = 1'b0;
		viol = 1'b0;
		resetn <= 1'b0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		cmd(1'b0, 18'h38000);
		repeat (12) @(posedge core_clk);
		loaded = 1'b1;
		cur = d ? 8'h7F : {b[7], 1'b1, b[5:0]};
		rd(4'h8, 8'hFF, cur);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		final_report();
	end
	initial begin
		for (int j = 0; j < 4; j++) begin
			rnd = lfsr(rnd);
			lat = 4'(2 * j);
			do_reset(rnd[7:0], j == 3);
			if (j == 0) begin
				bus(1'b1, 4'h8, 8'h7F, 4'hE);
				rd(4'h8, 8'hFF, cur);
				rd(4'hF, 8'hFF, 8'h00);
				for (int i = 0; i < 6; i++) begin
					ign = i > 2;
					en = 2'(i);
					t = i % 3;
					f = t == 0 ? {1'b0, !ign} : t == 1 ? 2'b10 : 2'b11;
					wr(4'h4, {3'h0, ign, 4'h0});
					wr(4'h5, {6'h0, en});
					ev(3'(1 << t));
					rd(4'h7, 8'h03, {6'h0, f});
					#1 chk(fault_irq === (f[1] & en[1] | f[0] & en[0] & !ign), "irq");
					wr(4'h7, 8'h00);
					rd(4'h7, 8'h03, {6'h0, f});
					wr(4'h7, 8'h03);
					rd(4'h7, 8'h03, 8'h00);
				end
			end
			for (int i = 0; i < 12; i++) begin
				rnd = lfsr(rnd);
				n = rnd[7:0];
				n[6] = cur[6];
				if (!cur[5]) n[4:3] = cur[4:3];
				if (!cur[2]) n[1:0] = cur[1:0];
				if (!shrinks(cur, n)) cur = n;
				wr(4'h8, rnd[7:0] | 8'h40);
				rd(4'h8, 8'hFF, cur);
				rnd = lfsr(rnd);
				cmd(rnd[15], {3'h7, rnd[14:0]});
				rd(4'h6, 8'h10, {3'h0, viol, 4'h0});
				if (rnd[3]) begin
					wr(4'h6, 8'h10);
					viol = 1'b0;
				end
			end
		end
		final_report();
	end
endmodule
`default_nettype wire
